// *** olhi_cfg.svh ***
`ifndef OLHI_CFG_SVH
`define OLHI_CFG_SVH
// timing, given in ns and converted to hclk cycles of the host end
`define OLHI_CLK_NS      100
`define OLHI_STROBE_NS   800
`define OLHI_STROBE_CYC  ((`OLHI_STROBE_NS + `OLHI_CLK_NS - 1) / `OLHI_CLK_NS)
`define OLHI_GAP_NS      400
`define OLHI_GAP_CYC     ((`OLHI_GAP_NS + `OLHI_CLK_NS - 1) / `OLHI_CLK_NS)
`define OLHI_SHALF_NS    400
`define OLHI_SHALF_CYC   (`OLHI_SHALF_NS / `OLHI_CLK_NS)
// pixel memory: 128 columns x 64 rows, one bit per pixel, as bytes
`define OLHI_MEM_BYTES   1024
`define OLHI_ADDR_W      10
// host register map, byte offsets
`define OLHI_REG_CTRL    8'h00
`define OLHI_REG_XFER    8'h04
`define OLHI_REG_STAT    8'h08
// field positions and reset values
`define OLHI_C_STRAP_A   0
`define OLHI_C_STRAP_B   1
`define OLHI_C_RELEASE   2
`define OLHI_CTRL_RST    3'h4
`define OLHI_X_DC        8
`define OLHI_X_RD        9
`define OLHI_S_BUSY      0
`endif

// *** olhi_pkg.sv ***
`include "olhi_cfg.svh"
package olhi_pkg;
  typedef enum logic [1:0] {
    OLHI_M6800  = 2'b00,
    OLHI_M8080  = 2'b01,
    OLHI_SERIAL = 2'b10
  } olhi_mode_e;

  typedef enum logic [1:0] {
    OLHI_IDLE   = 2'b00,
    OLHI_SETUP  = 2'b01,
    OLHI_STROBE = 2'b10,
    OLHI_HOLD   = 2'b11
  } olhi_hst_e;

  typedef struct packed {
    logic [14:0]                                  s1;
    logic [14:0]                                  s2;
    olhi_mode_e                                   mode;
    logic                                         prev_act;
    logic                                         prev_sclk;
    logic                                         is_rd;
    logic [7:0]                                   shift;
    logic [2:0]                                   bitcnt;
    logic [`OLHI_ADDR_W-1:0]                      ptr;
    logic [7:0]                                   dout;
    logic                                         oe;
    logic [7:0]                                   rdata;
    logic [`OLHI_MEM_BYTES-1:0][7:0]              mem;
  } olhi_dev_s;

  typedef struct packed {
    logic [2:0]  ctrl;
    logic [7:0]  xdata;
    logic        xdc;
    logic        xrd;
    olhi_hst_e   st;
    logic [3:0]  cnt;
    logic [2:0]  bitn;
    logic        half;
    logic [7:0]  rdata;
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic        a_act;
    logic        a_wr;
    logic [7:0]  a_addr;
    logic [31:0] hrdata;
  } olhi_host_s;
endpackage

// *** olhi_if.sv ***
`timescale 1ns/10ps
interface olhi_if;
  logic       cs_n;
  logic       dc;
  logic       rw_wr_n;
  logic       en_rd_n;
  logic       iface_strap_a;
  logic       iface_strap_b;
  logic       reset_n_in;
  logic [7:0] host_d;
  logic       host_oe;
  logic [7:0] dev_d;
  logic       dev_oe;
  logic [7:0] d_bus;

  // resolved level of the shared data lines, pulled high when nobody drives
  assign d_bus = dev_oe ? dev_d : (host_oe ? host_d : 8'hff);

  modport dev (
    input  cs_n, dc, rw_wr_n, en_rd_n, iface_strap_a, iface_strap_b, reset_n_in, d_bus,
    output dev_d, dev_oe
  );
  modport host (
    input  d_bus,
    output cs_n, dc, rw_wr_n, en_rd_n, iface_strap_a, iface_strap_b, reset_n_in, host_d, host_oe
  );
endinterface

// *** olhi_device.sv ***
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "olhi_cfg.svh"
module olhi_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } olhi_fifo_s;
  olhi_fifo_s r, n;

  // depth must be a power of two: pointers wrap by overflow
  assign in_ready  = !((r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]));
  assign out_valid = (r.wp != r.rp);
  assign out_data  = r.mem[r.rp[AW-1:0]];

  always_comb begin
    n = r;
    if (in_valid && in_ready) begin
      n.mem[r.wp[AW-1:0]] = in_data;
      n.wp = r.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      n.rp = r.rp + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule // olhi_fifo

// What this block does
// - straps pick 6800, 8080 or serial
// - transfers only while chip select low
// - dc high data, low command
// - host drives rw high read, low write
// - 6800 transfer starts on enable high
// - 8080 write starts on write strobe low
// - 8080 read drives bus on read strobe
// - eight bit bus, both directions
// - serial data on D1, clock on D0
// - one bit per pixel memory feeds panel
module olhi_device (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     ce,
  olhi_if.dev                           link,
  output logic                          cmd_valid,
  input  wire logic                     cmd_ready,
  output logic [7:0]                    cmd_byte,
  input  wire logic                     addr_load,
  input  wire logic [`OLHI_ADDR_W-1:0]  addr_value,
  input  wire logic [`OLHI_ADDR_W-1:0]  refresh_addr,
  output logic [7:0]                    refresh_data,
  output logic                          link_ready,
  output logic [1:0]                    mode_out
);
  olhi_pkg::olhi_dev_s r, n;
  logic [14:0] raw;
  logic        f_in_valid;
  logic [8:0]  f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [8:0]  f_out_data;
  logic        cs_n, dc, rw, en, rst_in_n, sa, sb;
  logic [7:0]  dq;

  assign raw = {link.cs_n, link.dc, link.rw_wr_n, link.en_rd_n, link.reset_n_in,
                link.iface_strap_a, link.iface_strap_b, link.d_bus};
  // only the second synchroniser stage is looked at
  assign {cs_n, dc, rw, en, rst_in_n, sa, sb, dq} = r.s2;

  olhi_fifo #(.W(9), .D(16)) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .in_valid  (f_in_valid),
    .in_ready  (link_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  assign cmd_valid    = f_out_valid && !f_out_data[8];
  assign cmd_byte     = f_out_data[7:0];
  assign f_out_ready  = f_out_data[8] || cmd_ready;
  assign link.dev_d   = r.dout;
  assign link.dev_oe  = r.oe;
  assign refresh_data = r.rdata;
  assign mode_out     = r.mode;

  always_comb begin
    logic act;
    logic rd_req;
    logic start;
    logic stop;
    logic sclk_rise;
    logic [1:0] inc;
    act = 1'b0;
    rd_req = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    sclk_rise = 1'b0;
    inc = 2'b00;
    n = r;
    f_in_valid = 1'b0;
    f_in_data = '0;
    n.s1 = raw;
    n.s2 = r.s1;
    n.rdata = r.mem[refresh_addr];
    unique case (r.mode)
      olhi_pkg::OLHI_M6800: begin
        act = !cs_n && en;
        rd_req = rw;
      end
      olhi_pkg::OLHI_M8080: begin
        act = !cs_n && (!rw || !en);
        rd_req = !en;
      end
      default: begin
        act = 1'b0;
        rd_req = 1'b0;
      end
    endcase
    start = act && !r.prev_act;
    stop = !act && r.prev_act;
    n.prev_act = act;
    sclk_rise = dq[0] && !r.prev_sclk;
    n.prev_sclk = dq[0];
    if (start) begin
      n.is_rd = rd_req;
      if (rd_req) begin
        n.dout = r.mem[r.ptr];
        n.oe = 1'b1;
      end
    end
    if (stop) begin
      n.oe = 1'b0;
      if (r.is_rd) begin
        inc = inc + 2'd1;
      end else begin
        // a full buffer drops the byte: the host cannot be stalled on the pins
        f_in_valid = 1'b1;
        f_in_data = {dc, dq};
      end
    end
    if (r.mode == olhi_pkg::OLHI_SERIAL) begin
      if (cs_n) begin
        n.bitcnt = '0;
      end else if (sclk_rise) begin
        n.shift = {r.shift[6:0], dq[1]};
        n.bitcnt = r.bitcnt + 3'd1;
        if (r.bitcnt == 3'd7) begin
          f_in_valid = 1'b1;
          f_in_data = {dc, r.shift[6:0], dq[1]};
        end
      end
    end
    if (f_out_valid && f_out_data[8]) begin
      n.mem[r.ptr] = f_out_data[7:0];
      inc = inc + 2'd1;
    end
    n.ptr = r.ptr + `OLHI_ADDR_W'(inc);
    if (addr_load) begin
      n.ptr = addr_value;
    end
    if (!rst_in_n) begin
      // straps are caught while the reset input is low
      n.mode = (sa && sb) ? olhi_pkg::OLHI_M8080 :
               (!sa && sb) ? olhi_pkg::OLHI_M6800 : olhi_pkg::OLHI_SERIAL;
      n.prev_act = 1'b0;
      n.is_rd = 1'b0;
      n.oe = 1'b0;
      n.bitcnt = '0;
      n.shift = '0;
      n.ptr = '0;
      f_in_valid = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule // olhi_device

// *** olhi_host.sv ***
`timescale 1ns/10ps
`include "olhi_cfg.svh"
module olhi_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  olhi_if.host             link,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  localparam logic [3:0] STROBE_CYC = 4'(`OLHI_STROBE_CYC);
  localparam logic [3:0] GAP_CYC    = 4'(`OLHI_GAP_CYC);
  localparam logic [3:0] SHALF_CYC  = 4'(`OLHI_SHALF_CYC);
  olhi_pkg::olhi_host_s r, n;
  logic serial, m6800, busy, strobe;

  // strap b low means serial whatever strap a says, the same decode as the device end
  assign serial    = !r.ctrl[`OLHI_C_STRAP_B];
  assign m6800     = !r.ctrl[`OLHI_C_STRAP_A] && r.ctrl[`OLHI_C_STRAP_B];
  assign busy      = (r.st != olhi_pkg::OLHI_IDLE);
  assign strobe    = (r.st == olhi_pkg::OLHI_STROBE) && !serial;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r.hrdata;

  assign link.iface_strap_a = r.ctrl[`OLHI_C_STRAP_A];
  assign link.iface_strap_b = r.ctrl[`OLHI_C_STRAP_B];
  assign link.reset_n_in    = r.ctrl[`OLHI_C_RELEASE];
  assign link.cs_n          = !busy;
  assign link.dc            = r.xdc;
  assign link.rw_wr_n       = m6800 ? r.xrd : !(strobe && !r.xrd);
  assign link.en_rd_n       = m6800 ? strobe : !(strobe && r.xrd);
  assign link.host_oe       = busy && (serial || !r.xrd);
  assign link.host_d        = serial ? {6'h00, r.xdata[3'd7 - r.bitn], !busy || r.half} : r.xdata;

  always_comb begin
    n = r;
    n.s1 = link.d_bus;
    n.s2 = r.s1;
    if (r.cnt != 4'h0) begin
      n.cnt = r.cnt - 4'h1;
    end
    unique case (r.st)
      olhi_pkg::OLHI_IDLE: begin
        n.half = 1'b1;
      end
      olhi_pkg::OLHI_SETUP: begin
        if (r.cnt == 4'h0) begin
          n.st = olhi_pkg::OLHI_STROBE;
          n.cnt = serial ? SHALF_CYC - 4'h1 : STROBE_CYC - 4'h1;
          n.half = 1'b0;
          n.bitn = '0;
        end
      end
      olhi_pkg::OLHI_STROBE: begin
        if (r.cnt == 4'h0) begin
          if (serial && !(r.half && r.bitn == 3'd7)) begin
            n.half = !r.half;
            n.bitn = r.half ? r.bitn + 3'd1 : r.bitn;
            n.cnt = SHALF_CYC - 4'h1;
          end else begin
            if (!serial && r.xrd) begin
              n.rdata = r.s2;
            end
            n.st = olhi_pkg::OLHI_HOLD;
            n.cnt = GAP_CYC - 4'h1;
          end
        end
      end
      olhi_pkg::OLHI_HOLD: begin
        if (r.cnt == 4'h0) begin
          n.st = olhi_pkg::OLHI_IDLE;
        end
      end
    endcase
    // ahb-lite: address phase is captured, write data lands in the data phase
    if (r.a_act && r.a_wr) begin
      if (r.a_addr == `OLHI_REG_CTRL) begin
        n.ctrl = hwdata[2:0];
      end
      // a transfer request while busy is dropped; software polls the busy bit
      if (r.a_addr == `OLHI_REG_XFER && !busy) begin
        n.xdata = hwdata[7:0];
        n.xdc = hwdata[`OLHI_X_DC];
        n.xrd = hwdata[`OLHI_X_RD] && !serial;            // serial is write-only
        n.st = olhi_pkg::OLHI_SETUP;
        n.cnt = GAP_CYC - 4'h1;
      end
    end
    n.a_act = hsel && htrans[1] && hready;
    n.a_wr = hwrite;
    n.a_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        `OLHI_REG_CTRL: n.hrdata = {29'h0, r.ctrl};
        `OLHI_REG_XFER: n.hrdata = {22'h0, r.xrd, r.xdc, r.xdata};
        `OLHI_REG_STAT: n.hrdata = {16'h0, r.rdata, 7'h0, busy};
        default:        n.hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.ctrl <= `OLHI_CTRL_RST;
      r.half <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule // olhi_host

// *** olhi_link_sva.sv ***
`timescale 1ns/10ps
module olhi_link_sva (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       cs_n,
  input wire logic       dc,
  input wire logic       rw_wr_n,
  input wire logic       en_rd_n,
  input wire logic       iface_strap_a,
  input wire logic       iface_strap_b,
  input wire logic       reset_n_in,
  input wire logic       host_oe,
  input wire logic       dev_oe,
  input wire logic [7:0] d_bus
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       m68;
  logic       m80;
  logic       sclk_r;
  logic [3:0] edges_r;
  assign m68 = !iface_strap_a && iface_strap_b;
  assign m80 = iface_strap_a && iface_strap_b;
  // edges counted only under chip select, so a frame with a missing or extra edge shows at its end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_r  <= 1'b1;
      edges_r <= 4'h0;
    end else begin
      sclk_r  <= d_bus[0];
      edges_r <= cs_n ? 4'h0 : edges_r + 4'(d_bus[0] && !sclk_r);
    end
  end
  sequence s_strobe8(logic sig);
    sig[*8] ##1 !sig;
  endsequence
  property p_strap_hold; !cs_n |-> $stable({iface_strap_a, iface_strap_b}); endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps moved in a transfer");
  property p_cs_idle; cs_n[*4] |-> !dev_oe; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("device drives while deselected");
  property p_dc_hold; !cs_n && !$past(cs_n) |-> $stable(dc); endproperty
  a_dc_hold: assert property (p_dc_hold) else $error("data select moved in a transfer");
  property p_rd68; m68 && !cs_n && rw_wr_n && $rose(en_rd_n) |-> ##[2:4] dev_oe; endproperty
  a_rd68: assert property (p_rd68) else $error("6800 read not driven");
  property p_en68; m68 && !cs_n && $rose(en_rd_n) |-> s_strobe8(en_rd_n); endproperty
  a_en68: assert property (p_en68) else $error("6800 enable length wrong");
  property p_wr80; m80 && !cs_n && $fell(rw_wr_n) |-> s_strobe8(!rw_wr_n); endproperty
  a_wr80: assert property (p_wr80) else $error("8080 write strobe length wrong");
  property p_rd80; m80 && !cs_n && $fell(en_rd_n) |-> ##[2:4] dev_oe; endproperty
  a_rd80: assert property (p_rd80) else $error("8080 read not driven");
  property p_no_fight; !(host_oe && dev_oe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive the bus");
  property p_ser_bits; !iface_strap_b && $rose(cs_n) |-> edges_r == 4'd8; endproperty
  a_ser_bits: assert property (p_ser_bits) else $error("serial frame edge count wrong");
  property p_link_rst; !reset_n_in[*4] |-> !dev_oe; endproperty
  a_link_rst: assert property (p_link_rst) else $error("device drives in link reset");
endmodule // olhi_link_sva

// *** oled_host_interface_tb.sv ***
`timescale 1ns/10ps
`include "olhi_cfg.svh"
module oled_host_interface_tb;
  localparam logic [1:0] STRAPS [3] = '{2'b10, 2'b11, 2'b00};
  localparam logic [1:0] MODES [3] = '{olhi_pkg::OLHI_M6800, olhi_pkg::OLHI_M8080, olhi_pkg::OLHI_SERIAL};
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout;
  logic        cmd_valid, cmd_ready, addr_load, link_ready;
  logic [1:0]  htrans, mode_out;
  logic [2:0]  hsize;
  logic [7:0]  cmd_byte, refresh_data, d, last0;
  logic [9:0]  addr_value, refresh_addr;
  logic [31:0] haddr, hwdata, hrdata, rdata_q;
  logic [7:0]  q[$];
  int          fail_count, total_checks;
  olhi_if lnk ();
  olhi_host i_olhi_host (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(lnk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata));
  olhi_device i_olhi_device (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(lnk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_byte(cmd_byte), .addr_load(addr_load), .addr_value(addr_value),
    .refresh_addr(refresh_addr), .refresh_data(refresh_data), .link_ready(link_ready), .mode_out(mode_out));
  olhi_link_sva i_olhi_link_sva (.hclk(hclk), .hresetn(hresetn), .cs_n(lnk.cs_n), .dc(lnk.dc),
    .rw_wr_n(lnk.rw_wr_n), .en_rd_n(lnk.en_rd_n), .iface_strap_a(lnk.iface_strap_a),
    .iface_strap_b(lnk.iface_strap_b), .reset_n_in(lnk.reset_n_in), .host_oe(lnk.host_oe),
    .dev_oe(lnk.dev_oe), .d_bus(lnk.d_bus));
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  // read data captured at the edge itself, so the bench never races the slave's flop
  always @(posedge hclk) rdata_q <= hrdata;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    #1 rd = rdata_q;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'b1, a, v, x);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] b);
    logic [31:0] x;
    wr(`OLHI_REG_XFER, {22'h0, rd, dc, b});
    for (int i = 0; i < 200; i++) begin
      ahb(1'b0, `OLHI_REG_STAT, 32'h0, x);
      if (x[0] === 1'b0) break;
    end
    chk(x[0], 1'b0);
  endtask
  task automatic set_mode(input logic [1:0] s);
    wr(`OLHI_REG_CTRL, {29'h0, 1'b0, s});
    repeat (4) @(posedge hclk);
    wr(`OLHI_REG_CTRL, {29'h0, 1'b1, s});
    repeat (4) @(posedge hclk);
  endtask
  task automatic ptr(input logic [9:0] v);
    @(posedge hclk);
    addr_value <= v;
    addr_load  <= 1'b1;
    @(posedge hclk);
    addr_load  <= 1'b0;
  endtask
  task automatic peek(input logic [9:0] a, input logic [7:0] exp);
    @(posedge hclk);
    refresh_addr <= a;
    repeat (2) @(posedge hclk);
    #1 chk(refresh_data, exp);
  endtask
  task automatic drain(input logic [7:0] exp[$]);
    int k = 0;
    @(posedge hclk);
    cmd_ready <= 1'b1;
    for (int i = 0; i < 100 && k < exp.size(); i++) begin
      @(negedge hclk);
      if (cmd_valid === 1'b1) begin
        chk(cmd_byte, exp[k]);
        k++;
      end
    end
    chk(k, exp.size());
    @(posedge hclk);
    cmd_ready <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0; hwdata = 0;
    cmd_ready = 0; addr_load = 0; addr_value = 0; refresh_addr = 0; fail_count = 0; total_checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`OLHI_REG_CTRL, {29'h0, `OLHI_CTRL_RST});
    rd_chk(`OLHI_REG_STAT, 32'h0);
    wr(32'h10, 32'hffff_ffff);
    rd_chk(32'h10, 32'h0);
    rd_chk(`OLHI_REG_CTRL, {29'h0, `OLHI_CTRL_RST});
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      d = 8'h5a + m[7:0];
      set_mode(STRAPS[m]);
      chk(mode_out, MODES[m]);
      ptr(10'h3ff);
      xfer(1'b0, 1'b1, d);
      xfer(1'b0, 1'b1, ~d);
      peek(10'h3ff, d);
      peek(10'h000, ~d);
      if (m < 2) begin
        ptr(10'h3ff);
        xfer(1'b1, 1'b1, 8'h00);
        rd_chk(`OLHI_REG_STAT, {16'h0, d, 8'h00});
      end
      xfer(1'b0, 1'b0, d ^ 8'h0f);
      drain('{d ^ 8'h0f});
      $display("test mode %0d done", m);
    end
    last0 = ~d;
    wr(`OLHI_REG_CTRL, {29'h0, 1'b0, 2'b11});
    ptr(10'h000);
    xfer(1'b0, 1'b1, 8'hc3);
    set_mode(2'b11);
    peek(10'h000, last0);
    $display("test link reset done");
    for (int i = 0; i < 17; i++) begin
      xfer(1'b0, 1'b0, 8'h80 + i[7:0]);
      if (i < 16) q.push_back(8'h80 + i[7:0]);
    end
    chk(link_ready, 1'b0);
    drain(q);
    // the last pop lands at the edge drain returns on, so look once it has settled
    @(negedge hclk);
    chk(cmd_valid, 1'b0);
    $display("test fifo done");
    summarize();
  end
endmodule // oled_host_interface_tb
